// >>> src/plcap_regs.sv
// How it works
// - Status bit shows transmit de-emphasis at 5 GT/s: 0 is -6 dB, 1 -3.5 dB.
// - At 2.5 GT/s the de-emphasis bit is undefined; nothing relies on it.
// - Slot capabilities, control and status two read zero, ignore writes.
// - Capability header low byte reads fixed identifier one.
// - Second header byte holds the next capability offset.
// - Three-bit revision field reads three.
// - Wake clock bit reads zero.
// - Device init bit resets to zero: no special init needed.
// - Auxiliary current field reads zero.
// - D1 and D2 support bits read zero.
// - Wake state support field resets to 11001 binary.
// - Wake messages are never forwarded in D3cold.
// - Writing wake state support changes only the advertised value.
`timescale 1ns/100ps
module plcap_regs
(
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [31:0] RDATA,
    input wire logic LINK_FAST,
    input wire logic TX_DEEMPH,
    input wire logic INIT_CFG,
    output logic CFG_LOCKED,
    output logic [4:0] WAKE_FWD_STATES
);

    // ************************************************************
    // Local state
    // ************************************************************
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [7:0] cap_ptr_ff;
    logic dev_init_ff;
    logic [4:0] wake_adv_ff;
    logic [4:0] fwd_states_ff;
    logic deemph_flag;
    logic wr_open;
    logic locked;
    logic pm_wr;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] pm_word
    (
        input logic [7:0] nxt,
        input logic dinit,
        input logic [4:0] wake
    );
        logic [31:0] w;
        w = plcap_pkg::RSVD_VAL;
        w[plcap_pkg::CAP_IDENT_LSB +: 8] = plcap_pkg::CAP_IDENT_VAL;
        w[plcap_pkg::NEXT_CAP_LSB +: 8] = nxt;
        w[plcap_pkg::REV_LSB +: 3] = plcap_pkg::REV_VAL;
        w[plcap_pkg::WAKECLK_BIT] = plcap_pkg::WAKECLK_VAL;
        w[plcap_pkg::DEVINIT_BIT] = dinit;
        w[plcap_pkg::AUXCUR_LSB +: 3] = plcap_pkg::AUXCUR_VAL;
        w[plcap_pkg::D1_BIT] = plcap_pkg::D1_VAL;
        w[plcap_pkg::D2_BIT] = plcap_pkg::D2_VAL;
        w[plcap_pkg::WAKE_LSB +: 5] = wake;
        return w;
    endfunction

    function automatic logic [4:0] fwd_mask(input logic [4:0] st);
        logic [4:0] m;
        m = st;
        m[plcap_pkg::WAKE_D3COLD_IDX] = 1'h0;
        return m;
    endfunction

    // ************************************************************
    // Sub-blocks
    // ************************************************************
    plcap_demph u_demph
    (
        .clk(REF_CLK),
        .rst_n(NRST),
        .link_fast(LINK_FAST),
        .tx_level(TX_DEEMPH),
        .deemph_flag_ff(deemph_flag)
    );

    plcap_lock u_lock
    (
        .clk(REF_CLK),
        .rst_n(NRST),
        .init_cfg(INIT_CFG),
        .wr_open(wr_open),
        .locked(locked)
    );

    // ************************************************************
    // Lockable capability fields
    // ************************************************************
    assign pm_wr = WR_STB && wr_open
        && (ADDR == plcap_pkg::OFS_POWER_MGMT_CAPABILITIES);

    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            cap_ptr_ff <= plcap_pkg::NEXT_CAP_RST;
            dev_init_ff <= plcap_pkg::DEVINIT_RST;
            wake_adv_ff <= plcap_pkg::WAKE_RST;
        end
        else if (pm_wr)
        begin
            cap_ptr_ff <= WDATA[plcap_pkg::NEXT_CAP_LSB +: 8];
            dev_init_ff <= WDATA[plcap_pkg::DEVINIT_BIT];
            wake_adv_ff <= WDATA[plcap_pkg::WAKE_LSB +: 5];
        end
    end

    // Forwarding follows the default states, never the advertised
    // copy, and drops D3cold since main power is gone there
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            fwd_states_ff <= 5'h00;
        else
            fwd_states_ff <= fwd_mask(plcap_pkg::WAKE_RST);
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Slot registers two and any unmapped offset fall to zero; the
    // bus has no error answer, so a stray read is silent
    always_comb
    begin
        nxt_rdata = plcap_pkg::RSVD_VAL;
        if (RD_STB)
        begin
            unique case (ADDR)
                plcap_pkg::OFS_LINK_STATUS_TWO:
                    nxt_rdata[plcap_pkg::DEEMPH_BIT] = deemph_flag;
                plcap_pkg::OFS_SLOT_CAPABILITIES_TWO,
                plcap_pkg::OFS_SLOT_CONTROL_TWO,
                plcap_pkg::OFS_SLOT_STATUS_TWO:
                    nxt_rdata = plcap_pkg::RSVD_VAL;
                plcap_pkg::OFS_POWER_MGMT_CAPABILITIES:
                    nxt_rdata = pm_word(cap_ptr_ff, dev_init_ff,
                        wake_adv_ff);
                default:
                    nxt_rdata = plcap_pkg::RSVD_VAL;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            rdata_ff <= plcap_pkg::RSVD_VAL;
        else
            rdata_ff <= nxt_rdata;
    end

    assign RDATA = rdata_ff;
    assign CFG_LOCKED = locked;
    assign WAKE_FWD_STATES = fwd_states_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);

    logic rd_pm;
    logic rd_slot;
    logic rd_link;
    logic rst_seen_ff;

    assign rd_pm = RD_STB
        && (ADDR == plcap_pkg::OFS_POWER_MGMT_CAPABILITIES);
    assign rd_slot = RD_STB
        && ((ADDR == plcap_pkg::OFS_SLOT_CAPABILITIES_TWO)
        || (ADDR == plcap_pkg::OFS_SLOT_CONTROL_TWO)
        || (ADDR == plcap_pkg::OFS_SLOT_STATUS_TWO));
    assign rd_link = RD_STB
        && (ADDR == plcap_pkg::OFS_LINK_STATUS_TWO);

    // Marks the first cycle after reset release
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            rst_seen_ff <= 1'h0;
        else
            rst_seen_ff <= 1'h1;
    end

    deemph_read_a: assert property (
        rd_link |=> (RDATA[0] == $past(deemph_flag))
            && (RDATA[15:1] == 15'h0000))
        else $error("de-emphasis read does not show the status flag");

    slot_zero_a: assert property (
        rd_slot |=> (RDATA == 32'h0000_0000))
        else $error("reserved slot register read was not zero");

    capability_identifier_fixed_a: assert property (
        rd_pm |=> (RDATA[7:0] == 8'h01))
        else $error("capability identifier is not one");

    next_ptr_a: assert property (
        rd_pm |=> (RDATA[15:8] == $past(cap_ptr_ff)))
        else $error("next pointer read differs from stored value");

    rev_fields_a: assert property (
        rd_pm |=> (RDATA[18:16] == 3'h3) && !RDATA[20])
        else $error("revision field is not three");

    wake_clock_a: assert property (
        rd_pm |=> !RDATA[19])
        else $error("wake clock bit is set");

    devinit_reset_a: assert property (
        !rst_seen_ff |-> !dev_init_ff)
        else $error("device init bit not zero after reset");

    aux_current_a: assert property (
        rd_pm |=> (RDATA[24:22] == 3'h0))
        else $error("aux current field is not zero");

    d1_d2_zero_a: assert property (
        rd_pm |=> (RDATA[26:25] == 2'h0))
        else $error("intermediate power state advertised");

    wake_reset_a: assert property (
        !rst_seen_ff |-> (wake_adv_ff == 5'h19))
        else $error("wake state support reset value wrong");

    no_d3cold_a: assert property (
        rst_seen_ff |-> !WAKE_FWD_STATES[4]
            && (WAKE_FWD_STATES == 5'h09))
        else $error("wake forwarding allowed in D3cold");

    adv_only_a: assert property (
        pm_wr ##1 rst_seen_ff |-> $stable(WAKE_FWD_STATES)
            && (wake_adv_ff == $past(WDATA[31:27])))
        else $error("advertised write changed forwarding behaviour");

    lock_hold_a: assert property (
        locked && WR_STB |=> $stable(cap_ptr_ff)
            && $stable(dev_init_ff) && $stable(wake_adv_ff))
        else $error("lockable field changed after init window");

    rdata_idle_a: assert property (
        !RD_STB |=> (RDATA == 32'h0000_0000))
        else $error("read data present without a read");

    load_write_c: cover property (pm_wr ##1 rd_pm);
    locked_write_c: cover property (locked && WR_STB
        && (ADDR == plcap_pkg::OFS_POWER_MGMT_CAPABILITIES));
    deemph_high_c: cover property (rd_link ##1 RDATA[0]);
    slot_read_c: cover property (rd_slot);

endmodule // plcap_regs

// >>> shared/plcap_pkg.sv
package plcap_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [11:0] OFS_LINK_STATUS_TWO = 12'h072;
    localparam logic [11:0] OFS_SLOT_CAPABILITIES_TWO = 12'h074;
    localparam logic [11:0] OFS_SLOT_CONTROL_TWO = 12'h078;
    localparam logic [11:0] OFS_SLOT_STATUS_TWO = 12'h07a;
    localparam logic [11:0] OFS_POWER_MGMT_CAPABILITIES = 12'h0c0;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int DEEMPH_BIT = 0;
    localparam int CAP_IDENT_LSB = 0;
    localparam int NEXT_CAP_LSB = 8;
    localparam int REV_LSB = 16;
    localparam int WAKECLK_BIT = 19;
    localparam int DEVINIT_BIT = 21;
    localparam int AUXCUR_LSB = 22;
    localparam int D1_BIT = 25;
    localparam int D2_BIT = 26;
    localparam int WAKE_LSB = 27;
    localparam int WAKE_D3COLD_IDX = 4;

    // ************************************************************
    // Fixed and reset values
    // ************************************************************
    localparam logic DEEMPH_RST = 1'h0;
    localparam logic [7:0] CAP_IDENT_VAL = 8'h01;
    localparam logic [7:0] NEXT_CAP_RST = 8'hd0;
    localparam logic [2:0] REV_VAL = 3'h3;
    localparam logic WAKECLK_VAL = 1'h0;
    localparam logic DEVINIT_RST = 1'h0;
    localparam logic [2:0] AUXCUR_VAL = 3'h0;
    localparam logic D1_VAL = 1'h0;
    localparam logic D2_VAL = 1'h0;
    localparam logic [4:0] WAKE_RST = 5'h19;
    localparam logic [31:0] RSVD_VAL = 32'h0000_0000;

    // ************************************************************
    // Init-time write window
    // ************************************************************
    typedef enum logic [2:0]
    {
        PLCAP_LK_IDLE = 3'b001,
        PLCAP_LK_LOAD = 3'b010,
        PLCAP_LK_SHUT = 3'b100
    } plcap_lock_t;

endpackage

// >>> src/plcap_demph.sv
`timescale 1ns/100ps
module plcap_demph
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_fast,
    input wire logic tx_level,
    output logic deemph_flag_ff
);
    logic [1:0] fast_sync_ff;
    logic [1:0] lvl_sync_ff;
    logic nxt_deemph_flag;

    // Both levels come from the PHY side; two stages each
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fast_sync_ff <= 2'h0;
            lvl_sync_ff <= 2'h0;
        end
        else
        begin
            fast_sync_ff <= {fast_sync_ff[0], link_fast};
            lvl_sync_ff <= {lvl_sync_ff[0], tx_level};
        end
    end

    // At the base rate the level means nothing, so the flag simply
    // keeps the last value seen at the fast rate
    always_comb
    begin
        nxt_deemph_flag = deemph_flag_ff;
        if (fast_sync_ff[1])
            nxt_deemph_flag = lvl_sync_ff[1];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            deemph_flag_ff <= plcap_pkg::DEEMPH_RST;
        else
            deemph_flag_ff <= nxt_deemph_flag;
    end

endmodule // plcap_demph

// >>> src/plcap_lock.sv
`timescale 1ns/100ps
module plcap_lock
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic init_cfg,
    output logic wr_open,
    output logic locked
);
    logic [1:0] init_sync_ff;
    plcap_pkg::plcap_lock_t state_ff;
    plcap_pkg::plcap_lock_t nxt_state;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            init_sync_ff <= 2'h0;
        else
            init_sync_ff <= {init_sync_ff[0], init_cfg};
    end

    // One load window per reset; once shut it stays shut
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            plcap_pkg::PLCAP_LK_IDLE:
                if (init_sync_ff[1])
                    nxt_state = plcap_pkg::PLCAP_LK_LOAD;
            plcap_pkg::PLCAP_LK_LOAD:
                if (!init_sync_ff[1])
                    nxt_state = plcap_pkg::PLCAP_LK_SHUT;
            plcap_pkg::PLCAP_LK_SHUT:
                nxt_state = plcap_pkg::PLCAP_LK_SHUT;
            default:
                nxt_state = plcap_pkg::PLCAP_LK_SHUT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_ff <= plcap_pkg::PLCAP_LK_IDLE;
        else
            state_ff <= nxt_state;
    end

    assign wr_open = (state_ff == plcap_pkg::PLCAP_LK_LOAD);
    assign locked = (state_ff == plcap_pkg::PLCAP_LK_SHUT);

endmodule // plcap_lock

// >>> test/plcap_regs_test.sv
`timescale 1ns/100ps
module plcap_regs_test;

    // ************************************************************
    // Stimulus and bookkeeping
    // ************************************************************
    logic REF_CLK;
    logic NRST;
    logic [11:0] ADDR;
    logic [31:0] WDATA;
    logic WR_STB;
    logic RD_STB;
    logic [31:0] RDATA;
    logic LINK_FAST;
    logic TX_DEEMPH;
    logic INIT_CFG;
    logic CFG_LOCKED;
    logic [4:0] WAKE_FWD_STATES;
    logic [31:0] exp_q[$];
    logic [11:0] adr_q[$];
    logic rd_pend;
    logic [31:0] seed;
    logic [31:0] wval;
    logic [31:0] cap;
    logic [31:0] gap;
    int num_errors;
    int checks;
    int cycles;

    // Bits that only the init window may store in the capability header
    localparam logic [31:0] LOCK_MASK = 32'hf820ff00;
    localparam logic [31:0] FIXED_BITS = 32'h00030001;

    plcap_regs uut
    (
        .REF_CLK(REF_CLK),
        .NRST(NRST),
        .ADDR(ADDR),
        .WDATA(WDATA),
        .WR_STB(WR_STB),
        .RD_STB(RD_STB),
        .RDATA(RDATA),
        .LINK_FAST(LINK_FAST),
        .TX_DEEMPH(TX_DEEMPH),
        .INIT_CFG(INIT_CFG),
        .CFG_LOCKED(CFG_LOCKED),
        .WAKE_FWD_STATES(WAKE_FWD_STATES)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    task automatic chk(input string name, input logic [31:0] expv,
                       input logic [31:0] got);
        checks++;
        if (got !== expv)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, expv, got);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ************************************************************
    // Bus tasks; strobes stay up so calls may run back to back
    // ************************************************************
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= 1'b1;
        RD_STB <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge REF_CLK);
        ADDR <= a;
        WR_STB <= 1'b0;
        RD_STB <= 1'b1;
        exp_q.push_back(e);
        adr_q.push_back(a);
    endtask

    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge REF_CLK);
            WR_STB <= 1'b0;
            RD_STB <= 1'b0;
            WDATA <= ~WDATA;
        end
    endtask

    initial
    begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    // ************************************************************
    // Monitor: read data stand only in the cycle after the strobe
    // ************************************************************
    always @(posedge REF_CLK)
        rd_pend <= RD_STB && NRST;

    // The clock's first fall at time zero comes before any edge has
    // loaded the read register, so watching starts after one edge
    always @(negedge REF_CLK)
    begin
        if (cycles > 0)
        begin
            if (rd_pend === 1'b1)
            begin
                if (exp_q.size() == 0)
                    chk("unexpected read", 32'h0, 32'hffffffff);
                else
                    chk($sformatf("rdata@%h", adr_q.pop_front()),
                        exp_q.pop_front(), RDATA);
            end
            else
                chk("idle rdata", 32'h0, RDATA);
        end
    end

    always @(posedge REF_CLK)
    begin
        cycles++;
        if (cycles >= 3000)
        begin
            num_errors++;
            $display("Error timeout expected done seen running");
            complete_run();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        NRST = 1'b0;
        ADDR = 12'h000;
        WDATA = 32'h0;
        WR_STB = 1'b0;
        RD_STB = 1'b0;
        LINK_FAST = 1'b0;
        TX_DEEMPH = 1'b0;
        INIT_CFG = 1'b0;
        num_errors = 0;
        checks = 0;
        cycles = 0;
        seed = 32'h76f5c14d;
        cap = 32'hc803d001;
        repeat (10) @(posedge REF_CLK);
        NRST <= 1'b1;
        rd(12'h072, 32'h0);
        rd(12'h074, 32'h0);
        rd(12'h078, 32'h0);
        rd(12'h07a, 32'h0);
        rd(12'h0c0, cap);
        rd(12'h076, 32'h0);
        idle(2);
        chk("fwd states", 32'h09, {27'h0, WAKE_FWD_STATES});
        chk("locked", 32'h0, {31'h0, CFG_LOCKED});
        // Writes before the first window are refused
        wr(12'h0c0, 32'hffffffff);
        wr(12'h074, 32'hffffffff);
        wr(12'h078, 32'hffffffff);
        wr(12'h07a, 32'hffffffff);
        wr(12'h072, 32'hffffffff);
        rd(12'h0c0, cap);
        rd(12'h074, 32'h0);
        rd(12'h078, 32'h0);
        rd(12'h07a, 32'h0);
        rd(12'h072, 32'h0);
        // De-emphasis flag follows the transmitter at the fast rate
        LINK_FAST <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            TX_DEEMPH <= seed[0];
            idle(4);
            rd(12'h072, {31'h0, seed[0]});
        end
        // Slow rate: level is undefined, so it is toggled but never read
        LINK_FAST <= 1'b0;
        TX_DEEMPH <= ~TX_DEEMPH;
        INIT_CFG <= 1'b1;
        idle(4);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            wval = seed;
            cap = (wval & LOCK_MASK) | FIXED_BITS;
            wr(12'h0c0, wval);
            rd(12'h0c0, cap);
        end
        wr(12'h074, 32'hffffffff);
        rd(12'h074, 32'h0);
        idle(2);
        chk("fwd after write", 32'h09, {27'h0, WAKE_FWD_STATES});
        chk("locked open", 32'h0, {31'h0, CFG_LOCKED});
        INIT_CFG <= 1'b0;
        idle(4);
        chk("locked shut", 32'h1, {31'h0, CFG_LOCKED});
        gap = ~cap;
        wr(12'h0c0, gap);
        rd(12'h0c0, cap);
        // A second window in the same reset stays shut
        INIT_CFG <= 1'b1;
        idle(5);
        wr(12'h0c0, gap);
        rd(12'h0c0, cap);
        idle(3);
        chk("fwd final", 32'h09, {27'h0, WAKE_FWD_STATES});
        // A fresh reset brings the stored fields back
        NRST <= 1'b0;
        INIT_CFG <= 1'b0;
        idle(3);
        NRST <= 1'b1;
        rd(12'h0c0, 32'hc803d001);
        idle(3);
        chk("locked reset", 32'h0, {31'h0, CFG_LOCKED});
        chk("queue empty", 32'h0, exp_q.size());
        complete_run();
    end

endmodule // plcap_regs_test
